// ==== common/suspend_pkg.sv ====
/*
  Constants, enumerations and timing counts shared by the suspend control
  and its testbench. Assumes a 100 MHz system clock.
*/
package suspend_pkg;
  localparam int OPC_BITS = 8;
  localparam logic [7:0] OPC_SUSPEND = 8'hb0;
  localparam logic [7:0] OPC_RESUME = 8'hd0;
  localparam logic [5:0] OPC_LAST_BIT = 6'h07;
  localparam logic [5:0] BIT_COUNT_SAT = 6'h3f;
  localparam int SECTOR_BITS = 4;
  localparam int PAGE_BITS = 12;
  localparam logic [7:0] UNDEF_BYTE = 8'hff;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SUSPEND_LATENCY_NS = 20000;
  localparam int RESUME_LATENCY_NS = 20000;
  localparam int SUSPEND_LATENCY_CYC = (SUSPEND_LATENCY_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                       (SUSPEND_LATENCY_NS / CLK_PERIOD_NS);
  localparam int RESUME_LATENCY_CYC = (RESUME_LATENCY_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                      (RESUME_LATENCY_NS / CLK_PERIOD_NS);
  localparam int LAT_BITS = 12;
  localparam logic [LAT_BITS-1:0] LAT_ZERO = 12'h000;
  localparam logic [LAT_BITS-1:0] LAT_ONE = 12'h001;

  typedef enum logic [1:0] {
    kind_prog_buf1,
    kind_prog_buf2,
    kind_page_erase,
    kind_sector_erase
  } op_kind_t;

  typedef enum logic [3:0] {
    cls_read_array,
    cls_read_buf1,
    cls_read_buf2,
    cls_write_buf1,
    cls_write_buf2,
    cls_prog_noerase,
    cls_prog_erase,
    cls_page_rewrite,
    cls_erase,
    cls_protect_change,
    cls_protect_read,
    cls_status_read,
    cls_other
  } cmd_class_t;

  typedef enum logic [1:0] {
    st_idle,
    st_suspending,
    st_resuming
  } ctl_state_t;
endpackage

// ==== hw/level_sync.sv ====
/*
  Two flip-flop synchroniser for a bundle of independent levels.
  Assumes each bit changes slowly compared with the destination clock.
*/
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage_one;
  logic [WIDTH-1:0] next_stage_one;
  logic [WIDTH-1:0] next_dout;

  if (WIDTH < 1) begin : width_check
    $error("level_sync needs a width of at least one.");
  end

  always_comb begin
    next_stage_one = din;
    next_dout = stage_one;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_one <= RESET_VALUE;
      dout <= RESET_VALUE;
    end else begin
      stage_one <= next_stage_one;
      dout <= next_dout;
    end
  end
endmodule

// ==== hw/program_erase_suspend_control.sv ====
/*
  Suspend control of the serial flash command sequencer: catches the
  suspend and resume opcodes on the serial link, tracks suspend flags and
  suspended sectors, gates commands and masks reads of suspended sectors.
  Assumes the program/erase engine and the command decoder share clk.
*/
`timescale 1ns/1ps
module program_erase_suspend_control #(
  parameter int SECTOR_W = suspend_pkg::SECTOR_BITS,
  parameter int PAGE_W = suspend_pkg::PAGE_BITS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic reset_pin_n,
  input wire logic soft_reset,
  input wire logic op_busy,
  input wire suspend_pkg::op_kind_t op_kind,
  input wire logic [SECTOR_W-1:0] op_sector,
  input wire logic [PAGE_W-1:0] op_page,
  input wire logic op_halted,
  input wire logic cmd_req,
  input wire suspend_pkg::cmd_class_t cmd_class,
  input wire logic [SECTOR_W-1:0] cmd_sector,
  input wire logic [SECTOR_W-1:0] rd_sector,
  input wire logic [7:0] rd_data_in,
  output logic halt_req,
  output logic resume_req,
  output logic resume_erase,
  output logic prog_suspend_buf_one_flag,
  output logic prog_suspend_buf_two_flag,
  output logic erase_suspend_flag,
  output logic ready,
  output logic cmd_grant,
  output logic cmd_deny,
  output logic prog_abort,
  output logic [7:0] rd_data_out,
  output logic lost_sector_valid,
  output logic [SECTOR_W-1:0] lost_sector,
  output logic lost_page_valid,
  output logic [PAGE_W-1:0] lost_page
);
  import suspend_pkg::*;

  if (SECTOR_W < 1 || PAGE_W <= SECTOR_W) begin : width_check
    $error("Page address must be wider than sector address.");
  end
  if (SUSPEND_LATENCY_CYC >= (1 << LAT_BITS) || RESUME_LATENCY_CYC >= (1 << LAT_BITS))
  begin : latency_check
    $error("Latency counts do not fit the latency counter.");
  end

  localparam logic [LAT_BITS-1:0] SUSP_LAST = LAT_BITS'(SUSPEND_LATENCY_CYC);
  localparam logic [LAT_BITS-1:0] RES_LAST = LAT_BITS'(RESUME_LATENCY_CYC);

  // Link side: bit counter is cleared whenever chip select is high.
  logic link_rst;
  logic [5:0] bit_count;
  logic [5:0] next_bit_count;
  logic [OPC_BITS-1:0] opcode;
  logic [OPC_BITS-1:0] next_opcode;
  logic opcode_full;
  logic next_opcode_full;

  assign link_rst = rst | cs_n;

  always_comb begin
    next_bit_count = bit_count;
    next_opcode = opcode;
    next_opcode_full = opcode_full;
    if (bit_count != BIT_COUNT_SAT) begin
      next_bit_count = bit_count + 6'h01;
    end
    if (!cs_n && bit_count <= OPC_LAST_BIT) begin
      next_opcode = {opcode[OPC_BITS-2:0], mosi};
      next_opcode_full = (bit_count == OPC_LAST_BIT);
    end
  end

  always_ff @(posedge link_clk or posedge link_rst) begin
    if (link_rst) begin
      bit_count <= 6'h00;
    end else begin
      bit_count <= next_bit_count;
    end
  end

  // Opcode stays put after the frame, so the system side may read it once cs_n rose.
  always_ff @(posedge link_clk or posedge rst) begin
    if (rst) begin
      opcode <= 8'h00;
      opcode_full <= 1'b0;
    end else begin
      opcode <= next_opcode;
      opcode_full <= next_opcode_full;
    end
  end

  // System side: synchronised pins.
  logic [1:0] pins_sync;
  logic cs_n_prev;
  logic frame_end;
  logic pin_reset;

  level_sync #(
    .WIDTH(2),
    .RESET_VALUE(2'h3)
  ) pin_sync (
    .clk(clk),
    .rst(rst),
    .din({cs_n, reset_pin_n}),
    .dout(pins_sync)
  );

  assign frame_end = pins_sync[1] && !cs_n_prev;
  assign pin_reset = !pins_sync[0];

  function automatic logic sector_hit(input logic [SECTOR_W-1:0] sec,
                                      input logic es,
                                      input logic ps,
                                      input logic [SECTOR_W-1:0] es_sec,
                                      input logic [SECTOR_W-1:0] ps_sec);
    sector_hit = (es && sec == es_sec) || (ps && sec == ps_sec);
  endfunction

  function automatic logic cmd_allowed(input cmd_class_t cls,
                                       input logic ps1,
                                       input logic ps2,
                                       input logic es);
    logic any;
    any = ps1 | ps2 | es;
    case (cls)
      cls_write_buf1: cmd_allowed = !ps1;
      cls_write_buf2: cmd_allowed = !ps2;
      cls_prog_noerase: cmd_allowed = !(ps1 | ps2);
      cls_prog_erase, cls_page_rewrite, cls_erase: cmd_allowed = !any;
      cls_protect_change: cmd_allowed = !any;
      default: cmd_allowed = 1'b1;
    endcase
  endfunction

  ctl_state_t state;
  ctl_state_t next_state;
  logic [LAT_BITS-1:0] lat_count;
  logic [LAT_BITS-1:0] next_lat_count;
  logic erase_is_page;
  logic next_erase_is_page;
  logic [SECTOR_W-1:0] erase_sector;
  logic [SECTOR_W-1:0] next_erase_sector;
  logic [PAGE_W-1:0] erase_page;
  logic [PAGE_W-1:0] next_erase_page;
  logic [SECTOR_W-1:0] prog_sector;
  logic [SECTOR_W-1:0] next_prog_sector;
  logic [PAGE_W-1:0] prog_page;
  logic [PAGE_W-1:0] next_prog_page;
  logic next_halt_req;
  logic next_resume_req;
  logic next_resume_erase;
  logic next_ps1;
  logic next_ps2;
  logic next_es;
  logic next_ready;
  logic next_cmd_grant;
  logic next_cmd_deny;
  logic next_prog_abort;
  logic [7:0] next_rd_data_out;
  logic next_lost_sector_valid;
  logic [SECTOR_W-1:0] next_lost_sector;
  logic next_lost_page_valid;
  logic [PAGE_W-1:0] next_lost_page;
  logic is_suspend;
  logic is_resume;
  logic ps_any;
  logic prog_class;

  always_comb begin
    next_state = state;
    next_lat_count = lat_count;
    next_erase_is_page = erase_is_page;
    next_erase_sector = erase_sector;
    next_erase_page = erase_page;
    next_prog_sector = prog_sector;
    next_prog_page = prog_page;
    next_halt_req = halt_req;
    next_resume_req = 1'b0;
    next_resume_erase = resume_erase;
    next_ps1 = prog_suspend_buf_one_flag;
    next_ps2 = prog_suspend_buf_two_flag;
    next_es = erase_suspend_flag;
    next_cmd_grant = 1'b0;
    next_cmd_deny = 1'b0;
    next_prog_abort = 1'b0;
    next_lost_sector_valid = 1'b0;
    next_lost_sector = lost_sector;
    next_lost_page_valid = 1'b0;
    next_lost_page = lost_page;
    ps_any = prog_suspend_buf_one_flag | prog_suspend_buf_two_flag;
    is_suspend = frame_end && opcode_full && opcode == OPC_SUSPEND;
    is_resume = frame_end && opcode_full && opcode == OPC_RESUME;
    prog_class = cmd_class == cls_prog_noerase || cmd_class == cls_prog_erase;

    case (state)
      st_idle: begin
        if (is_suspend && op_busy) begin
          next_state = st_suspending;
          next_halt_req = 1'b1;
          next_lat_count = LAT_ONE;
        end else if (is_resume && ps_any) begin
          next_ps1 = 1'b0;
          next_ps2 = 1'b0;
          next_resume_req = 1'b1;
          next_resume_erase = 1'b0;
          next_state = st_resuming;
          next_lat_count = LAT_ONE;
        end else if (is_resume && erase_suspend_flag) begin
          next_es = 1'b0;
          next_resume_req = 1'b1;
          next_resume_erase = 1'b1;
          next_state = st_resuming;
          next_lat_count = LAT_ONE;
        end
      end
      st_suspending: begin
        next_lat_count = lat_count + LAT_ONE;
        if (op_halted || lat_count == SUSP_LAST) begin
          next_halt_req = 1'b0;
          next_state = st_idle;
          next_lat_count = LAT_ZERO;
          case (op_kind)
            kind_prog_buf1: begin
              next_ps1 = 1'b1;
              next_prog_sector = op_sector;
              next_prog_page = op_page;
            end
            kind_prog_buf2: begin
              next_ps2 = 1'b1;
              next_prog_sector = op_sector;
              next_prog_page = op_page;
            end
            default: begin
              next_es = 1'b1;
              next_erase_is_page = op_kind == kind_page_erase;
              next_erase_sector = op_sector;
              next_erase_page = op_page;
            end
          endcase
        end
      end
      default: begin
        // Suspend frames fall through here unanswered while resuming.
        next_lat_count = lat_count + LAT_ONE;
        if (lat_count == RES_LAST) begin
          next_state = st_idle;
          next_lat_count = LAT_ZERO;
        end
      end
    endcase

    if (cmd_req) begin
      if (!cmd_allowed(cmd_class, prog_suspend_buf_one_flag, prog_suspend_buf_two_flag,
                       erase_suspend_flag)) begin
        next_cmd_deny = 1'b1;
      end else if (prog_class && erase_suspend_flag && cmd_sector == erase_sector) begin
        next_prog_abort = 1'b1;
      end else begin
        next_cmd_grant = 1'b1;
      end
    end

    if (soft_reset || pin_reset) begin
      next_lost_sector_valid = erase_suspend_flag && !erase_is_page;
      next_lost_sector = erase_sector;
      next_lost_page_valid = ps_any || (erase_suspend_flag && erase_is_page);
      next_lost_page = ps_any ? prog_page : erase_page;
      next_ps1 = 1'b0;
      next_ps2 = 1'b0;
      next_es = 1'b0;
      next_halt_req = 1'b0;
      next_state = st_idle;
      next_lat_count = LAT_ZERO;
    end

    next_ready = next_state == st_idle && !op_busy && !next_resume_req;
    if (sector_hit(rd_sector, erase_suspend_flag, ps_any, erase_sector, prog_sector)) begin
      next_rd_data_out = UNDEF_BYTE;
    end else begin
      next_rd_data_out = rd_data_in;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cs_n_prev <= 1'b1;
      state <= st_idle;
      lat_count <= LAT_ZERO;
      erase_is_page <= 1'b0;
      erase_sector <= '0;
      erase_page <= '0;
      prog_sector <= '0;
      prog_page <= '0;
      halt_req <= 1'b0;
      resume_req <= 1'b0;
      resume_erase <= 1'b0;
      prog_suspend_buf_one_flag <= 1'b0;
      prog_suspend_buf_two_flag <= 1'b0;
      erase_suspend_flag <= 1'b0;
      ready <= 1'b0;
      cmd_grant <= 1'b0;
      cmd_deny <= 1'b0;
      prog_abort <= 1'b0;
      rd_data_out <= 8'h00;
      lost_sector_valid <= 1'b0;
      lost_sector <= '0;
      lost_page_valid <= 1'b0;
      lost_page <= '0;
    end else begin
      cs_n_prev <= pins_sync[1];
      state <= next_state;
      lat_count <= next_lat_count;
      erase_is_page <= next_erase_is_page;
      erase_sector <= next_erase_sector;
      erase_page <= next_erase_page;
      prog_sector <= next_prog_sector;
      prog_page <= next_prog_page;
      halt_req <= next_halt_req;
      resume_req <= next_resume_req;
      resume_erase <= next_resume_erase;
      prog_suspend_buf_one_flag <= next_ps1;
      prog_suspend_buf_two_flag <= next_ps2;
      erase_suspend_flag <= next_es;
      ready <= next_ready;
      cmd_grant <= next_cmd_grant;
      cmd_deny <= next_cmd_deny;
      prog_abort <= next_prog_abort;
      rd_data_out <= next_rd_data_out;
      lost_sector_valid <= next_lost_sector_valid;
      lost_sector <= next_lost_sector;
      lost_page_valid <= next_lost_page_valid;
      lost_page <= next_lost_page;
    end
  end
endmodule

// ==== tb/spi_host_model.sv ====
/*
  Behavioural serial host that sends opcode frames on the link.
  Assumes mode 0 framing; the 160 ns link clock stops between frames.
*/
`timescale 1ns/1ps
module spi_host_model (
  output logic link_clk,
  output logic cs_n,
  output logic mosi
);
  initial begin
    link_clk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // Sends the top n bits of d first; the idle line shows the inverse.
  task automatic frame(input logic [15:0] d, input int n);
    logic last;
    last = 1'b0;
    #45;
    cs_n = 1'b0;
    for (int i = 15; i > 15 - n; i--) begin
      mosi = d[i];
      last = d[i];
      #80 link_clk = 1'b1;
      #80 link_clk = 1'b0;
    end
    #40 cs_n = 1'b1;
    mosi = ~last;
  endtask
endmodule

// ==== tb/suspend_ctl_props.sv ====
/*
  Concurrent checks on the suspend control ports.
  Assumes a single clk domain with active-high asynchronous rst.
*/
`timescale 1ns/1ps
module suspend_ctl_props import suspend_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic soft_reset,
  input wire logic op_halted,
  input wire logic cmd_req,
  input wire suspend_pkg::cmd_class_t cmd_class,
  input wire logic [7:0] rd_data_in,
  input wire logic halt_req,
  input wire logic resume_req,
  input wire logic prog_suspend_buf_one_flag,
  input wire logic prog_suspend_buf_two_flag,
  input wire logic erase_suspend_flag,
  input wire logic ready,
  input wire logic cmd_grant,
  input wire logic cmd_deny,
  input wire logic prog_abort,
  input wire logic [7:0] rd_data_out,
  input wire logic lost_sector_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic any_ps;
  logic any_fl;
  logic req;
  assign any_ps = prog_suspend_buf_one_flag | prog_suspend_buf_two_flag;
  assign any_fl = any_ps | erase_suspend_flag;
  assign req = cmd_req & ~soft_reset;
  // Ready stays low for the first cycles of a resume.
  sequence s_busy8;
    (!ready)[*8];
  endsequence
  chk_one_answer: assert property (
    cmd_req |=> $onehot({cmd_grant, cmd_deny, prog_abort}))
    else $error("command request without exactly one answer");
  chk_deny_wbuf1: assert property (
    req && cmd_class == cls_write_buf1 && prog_suspend_buf_one_flag |=> cmd_deny)
    else $error("buffer one write not refused");
  chk_deny_wbuf2: assert property (
    req && cmd_class == cls_write_buf2 && prog_suspend_buf_two_flag |=> cmd_deny)
    else $error("buffer two write not refused");
  chk_deny_erase: assert property (
    req && any_fl && cmd_class inside {cls_prog_erase, cls_page_rewrite, cls_erase,
    cls_protect_change} |=> cmd_deny)
    else $error("erase or protection change not refused");
  chk_grant_reads: assert property (
    req && cmd_class inside {cls_read_array, cls_read_buf1, cls_read_buf2,
    cls_protect_read, cls_status_read} |=> cmd_grant)
    else $error("read command not granted");
  chk_deny_noerase: assert property (
    req && any_ps && cmd_class == cls_prog_noerase |=> cmd_deny)
    else $error("program without erase not refused");
  chk_read_pass: assert property (
    !any_fl |=> rd_data_out == $past(rd_data_in))
    else $error("read data altered with nothing suspended");
  chk_halt_done: assert property (
    halt_req && op_halted |=> !halt_req)
    else $error("halt request outlived halt");
  chk_halt_flag: assert property (
    $fell(halt_req) && reset_pin_n && !$past(soft_reset) |-> any_fl)
    else $error("halt ended without suspend flag");
  chk_resume_busy: assert property (
    resume_req |-> s_busy8)
    else $error("ready during resume");
  chk_lost_clears: assert property (
    lost_sector_valid |-> !any_fl && !halt_req)
    else $error("reset left suspend state");
endmodule

// ==== tb/tb_top.sv ====
/*
  Testbench for the suspend control: link frames, command gate, read mask.
  Assumes the host model drives the link and the bench plays the engine.
*/
`timescale 1ns/1ps
module tb_top;
  import suspend_pkg::*;
  localparam logic [2:0] G = 3'h1;
  localparam logic [2:0] D = 3'h2;
  localparam logic [2:0] A = 3'h4;
  logic clk, rst, link_clk, cs_n, mosi, reset_pin_n, soft_reset, op_busy, op_halted;
  logic cmd_req, halt_req, resume_req, resume_erase, ready, cmd_grant, cmd_deny, prog_abort;
  logic prog_suspend_buf_one_flag, prog_suspend_buf_two_flag, erase_suspend_flag;
  logic lost_sector_valid, lost_page_valid;
  op_kind_t op_kind;
  cmd_class_t cmd_class;
  logic [3:0] op_sector, cmd_sector, rd_sector, lost_sector;
  logic [11:0] op_page, lost_page;
  logic [7:0] rd_data_in, rd_data_out;
  int err_count, compares, n;
  program_erase_suspend_control uut (.clk, .rst, .link_clk, .cs_n, .mosi, .reset_pin_n,
    .soft_reset, .op_busy, .op_kind, .op_sector, .op_page, .op_halted, .cmd_req,
    .cmd_class, .cmd_sector, .rd_sector, .rd_data_in, .halt_req, .resume_req,
    .resume_erase, .prog_suspend_buf_one_flag, .prog_suspend_buf_two_flag,
    .erase_suspend_flag, .ready, .cmd_grant, .cmd_deny, .prog_abort, .rd_data_out,
    .lost_sector_valid, .lost_sector, .lost_page_valid, .lost_page);
  spi_host_model u_host (.link_clk, .cs_n, .mosi);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic flags(input logic [3:0] e);
    chk(16'({prog_suspend_buf_one_flag, prog_suspend_buf_two_flag, erase_suspend_flag,
      ready}), 16'(e));
  endtask
  task automatic cmd(input cmd_class_t c, input logic [3:0] s, input logic [2:0] e);
    @(posedge clk);
    cmd_req <= 1'b1;
    cmd_class <= c;
    cmd_sector <= s;
    @(posedge clk);
    cmd_req <= 1'b0;
    #1;
    chk(16'({prog_abort, cmd_deny, cmd_grant}), 16'(e));
  endtask
  task automatic busy(input op_kind_t k, input logic [3:0] s);
    @(posedge clk);
    op_busy <= 1'b1;
    op_kind <= k;
    op_sector <= s;
  endtask
  task automatic suspend(input op_kind_t k, input logic [3:0] s, input logic [3:0] e);
    busy(k, s);
    op_page <= {8'h0a, s};
    u_host.frame(16'hb0c3, 16);
    cyc(6);
    chk(16'({halt_req, ready}), 16'h2);
    @(posedge clk);
    op_halted <= 1'b1;
    op_busy <= 1'b0;
    @(posedge clk);
    op_halted <= 1'b0;
    cyc(1);
    chk(16'(halt_req), 16'h0);
    flags(e);
  endtask
  task automatic soft_rst(input logic [15:0] e);
    @(posedge clk);
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    #1;
    chk(16'({lost_page_valid, lost_sector_valid, lost_page}), e);
    flags(4'h1);
  endtask
  task automatic resume(input logic e);
    u_host.frame(16'hd000, 8);
    n = 0;
    while (resume_req !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    chk(16'({resume_req, resume_erase, ready}), 16'({1'b1, e, 1'b0}));
  endtask
  task automatic summarize();
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    summarize();
  end
  initial begin
    {rst, reset_pin_n} = 2'b11;
    {soft_reset, op_busy, op_halted, cmd_req} = 4'h0;
    op_kind = kind_prog_buf1;
    cmd_class = cls_other;
    {op_sector, cmd_sector, rd_sector} = 12'h000;
    op_page = 12'h000;
    rd_data_in = 8'h00;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    cyc(2);
    chk(16'(ready), 16'h1);
    for (int c = 0; c < 13; c++) cmd(cmd_class_t'(4'(c)), 4'h3, G);
    u_host.frame(16'hb000, 8);
    cyc(8);
    chk(16'({halt_req, prog_suspend_buf_one_flag, erase_suspend_flag}), 16'h0);
    suspend(kind_sector_erase, 4'h3, 4'h3);
    for (int s = 2; s < 5; s++) begin
      @(posedge clk);
      rd_sector <= 4'(s);
      rd_data_in <= 8'(8'h50 + s);
      cyc(1);
      chk(16'(rd_data_out), (s == 3) ? 16'hff : 16'(8'h50 + s));
    end
    cmd(cls_read_array, 4'h3, G);
    cmd(cls_read_buf1, 4'h3, G);
    cmd(cls_read_buf2, 4'h3, G);
    cmd(cls_write_buf1, 4'h3, G);
    cmd(cls_prog_noerase, 4'h4, G);
    cmd(cls_prog_noerase, 4'h3, A);
    cmd(cls_prog_erase, 4'h4, D);
    cmd(cls_page_rewrite, 4'h4, D);
    cmd(cls_erase, 4'h4, D);
    cmd(cls_protect_change, 4'h4, D);
    cmd(cls_protect_read, 4'h4, G);
    cmd(cls_status_read, 4'h4, G);
    suspend(kind_prog_buf1, 4'h5, 4'hb);
    cmd(cls_write_buf1, 4'h5, D);
    cmd(cls_write_buf2, 4'h5, G);
    cmd(cls_prog_noerase, 4'h4, D);
    resume(1'b0);
    flags(4'h2);
    busy(kind_prog_buf1, 4'h5);
    u_host.frame(16'hb000, 8);
    cyc(6);
    chk(16'(halt_req), 16'h0);
    @(posedge clk);
    op_busy <= 1'b0;
    cyc(2100);
    chk(16'(ready), 16'h1);
    resume(1'b1);
    flags(4'h0);
    busy(kind_sector_erase, 4'h3);
    cyc(2100);
    suspend(kind_sector_erase, 4'h3, 4'h3);
    @(posedge clk);
    reset_pin_n <= 1'b0;
    n = 0;
    while (lost_sector_valid !== 1'b1 && n < 10) begin
      cyc(1);
      n++;
    end
    chk(16'({lost_page_valid, lost_sector_valid, lost_sector}), 16'h13);
    flags(4'h1);
    @(posedge clk);
    reset_pin_n <= 1'b1;
    cyc(4);
    suspend(kind_page_erase, 4'h6, 4'h3);
    suspend(kind_prog_buf2, 4'h7, 4'h7);
    @(posedge clk);
    rd_sector <= 4'h7;
    cyc(1);
    chk(16'(rd_data_out), 16'hff);
    cmd(cls_write_buf2, 4'h7, D);
    cmd(cls_write_buf1, 4'h7, G);
    soft_rst(16'h20a7);
    suspend(kind_page_erase, 4'h2, 4'h3);
    soft_rst(16'h20a2);
    summarize();
  end
endmodule
bind program_erase_suspend_control suspend_ctl_props u_props (.clk, .rst, .reset_pin_n,
  .soft_reset, .op_halted, .cmd_req, .cmd_class, .rd_data_in, .halt_req, .resume_req,
  .prog_suspend_buf_one_flag, .prog_suspend_buf_two_flag, .erase_suspend_flag, .ready,
  .cmd_grant, .cmd_deny, .prog_abort, .rd_data_out, .lost_sector_valid);
